// >>> rtl/capture_interrupt_status.sv
// Purpose: capture device interrupt status, mask and pin control over AXI4-Lite
// Assumes: event inputs are one-cycle pulses on aclk; the pin is asynchronous
// Notes:   write and read channels are served independently
// Notes on behaviour
// - sticky bits clear only where software writes a one
// - all event and status bits readable at any time
// - program status nibble set and reset by instruction bits, no interrupt
// - running bit reads program enable state, no interrupt
// - ack bit sets on good serial completion, clears on unacked done
// - field bit shows current field, 0 odd, 1 even
// - sync count error sets on counter overflow or sync code mismatch
// - opcode error sets on reserved opcode or reserved sync status
// - bus abort flag sets on master or target abort
// - instruction parity error with response enabled sets flag, stops dma
// - bus parity error sets on any parity error, ignoring response enable
// - stream resync flag sets on pixel, line or mode count mismatch
// - target latency overrun flag sets on overrun-terminated transaction
// - dropped data flag sets when overrun drops dwords
// - program interrupt flag sets on instruction irq bit
// - general pin event sets on programmed edge or level of pin
// - serial bus done flag sets when serial operation completes
// - video presence change sets when video appears or disappears
// - horizontal lock change sets on lock state change either way
// - converter overflow flag sets on luma or chroma overflow
// - line start flag sets on new line or horizontal reset edge
// - field change and format change flags set on their events
// - mask bit one lets the same event bit request interrupt
// - unmasking a pending bit raises the request at once
// - interrupt output is a level held until cleared or masked
// - polarity bit inverts pin; mode bit picks level or rising edge
`timescale 1ns/1ps
module capture_interrupt_status
  import irq_status_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  pstat_set,
  input  wire logic [3:0]  pstat_clr,
  input  wire logic        serial_ok,
  input  wire logic        serial_bus_done,
  input  wire logic        field_even,
  input  wire logic        eol_overflow,
  input  wire logic        sync_mismatch,
  input  wire logic        bad_opcode,
  input  wire logic        bad_sync_status,
  input  wire logic        master_abort,
  input  wire logic        target_abort,
  input  wire logic        parity_resp_en,
  input  wire logic        fetch_parity_err,
  input  wire logic        any_parity_err,
  input  wire logic        stream_resync,
  input  wire logic        target_latency_overrun,
  input  wire logic        dropped_data_overrun,
  input  wire logic        instr_irq,
  input  wire logic        general_interrupt_pin,
  input  wire logic        video_presence_change,
  input  wire logic        horizontal_lock_change,
  input  wire logic        converter_overflow,
  input  wire logic        new_line,
  input  wire logic        horizontal_reset_input,
  input  wire logic        field_change,
  input  wire logic        format_change,
  output logic             dma_program_enable,
  output logic             fifo_enable,
  output logic             irq
);

  typedef struct packed {
    logic        aw_got;
    logic [11:0] awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  pstat;
    logic        ack;
    logic        field;
    logic [23:0] sticky;
    logic [23:0] mask;
    logic [31:0] ctl;
    logic [2:0]  pin_sync;
    logic        pin_level;
    logic        pin_prev;
    logic        hr_prev;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        arready;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [23:0] hw_set;
  logic [23:0] sw_clr;
  logic [31:0] status_word;
  logic [31:0] mask_word;
  logic        pin_in;
  logic        do_write;
  logic        do_read;

  always_comb begin
    // the pin is sampled only once the second and third stages agree
    pin_in = s_q.pin_level ^ s_q.ctl[CTL_INV_BIT];
    hw_set = '0;
    hw_set[19] = eol_overflow | sync_mismatch;
    hw_set[18] = bad_opcode | bad_sync_status;
    hw_set[17] = master_abort | target_abort;
    hw_set[16] = parity_resp_en & fetch_parity_err;
    hw_set[15] = any_parity_err;
    hw_set[14] = stream_resync;
    hw_set[13] = target_latency_overrun;
    hw_set[12] = dropped_data_overrun;
    hw_set[11] = instr_irq;
    hw_set[9]  = s_q.ctl[CTL_EDGE_BIT] ? (pin_in & ~s_q.pin_prev) : pin_in;
    hw_set[8]  = serial_bus_done;
    hw_set[5]  = video_presence_change;
    hw_set[4]  = horizontal_lock_change;
    hw_set[3]  = converter_overflow;
    hw_set[2]  = new_line | (horizontal_reset_input & ~s_q.hr_prev);
    hw_set[1]  = field_change;
    hw_set[0]  = format_change;
    status_word = {s_q.pstat, s_q.ctl[CTL_DMA_BIT], 1'b0, s_q.ack,
                   s_q.field, s_q.sticky};
  end

  always_comb begin
    s_d = s_q;
    sw_clr = '0;
    mask_word = '0;
    s_d.pin_sync = {s_q.pin_sync[1:0], general_interrupt_pin};
    if (s_q.pin_sync[2] == s_q.pin_sync[1]) begin
      s_d.pin_level = s_q.pin_sync[2];
    end
    s_d.pin_prev = pin_in;
    s_d.hr_prev = horizontal_reset_input;
    s_d.field = field_even;
    s_d.pstat = (s_q.pstat | pstat_set) & ~pstat_clr;
    if (serial_ok) begin
      s_d.ack = 1'b1;
    end else if (serial_bus_done) begin
      s_d.ack = 1'b0;
    end
    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case ({s_q.awaddr[11:2], 2'b00})
        ADDR_STATUS: begin
          for (int i = 0; i < 3; i++) begin
            if (s_q.wstrb[i]) begin
              sw_clr[i*8 +: 8] = s_q.wdata[i*8 +: 8];
            end
          end
        end
        ADDR_MASK: begin
          mask_word = merge({8'h00, s_q.mask}, s_q.wdata, s_q.wstrb);
          s_d.mask = mask_word[MASK_W-1:0];
        end
        ADDR_CONTROL: begin
          s_d.ctl = merge(s_q.ctl, s_q.wdata, s_q.wstrb) & CTL_WMASK;
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // set after clear so a coincident event is kept
    s_d.sticky = ((s_q.sticky & ~sw_clr) | hw_set) & STICKY_BITS;
    if (hw_set[16]) begin
      s_d.ctl[CTL_DMA_BIT] = 1'b0;
    end
    do_read = s_axi_arvalid && s_q.arready;
    if (do_read) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        ADDR_STATUS:  s_d.rdata = status_word;
        ADDR_MASK:    s_d.rdata = {8'h00, s_q.mask};
        ADDR_CONTROL: s_d.rdata = s_q.ctl;
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // readies are registered so no bus output has logic behind its flop
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
    // level request from the next-state flags, so unmask acts at once
    s_d.irq = |(s_d.sticky & s_d.mask);
    if (!aresetn) begin
      s_d = '0;
      s_d.mask = MASK_RESET;
      s_d.ctl = CTL_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign dma_program_enable = s_q.ctl[CTL_DMA_BIT];
  assign fifo_enable = s_q.ctl[CTL_FIFO_BIT];
  assign irq = s_q.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence parity_stop_s;
    parity_resp_en && fetch_parity_err;
  endsequence

  sequence pin_rise_s;
    s_q.ctl[CTL_EDGE_BIT] && pin_in && !s_q.pin_prev;
  endsequence

  a_irq_level: assert property (
    irq == |($past(s_d.sticky) & $past(s_d.mask)))
    else $error("irq not level of masked flags");
  a_abort_sets: assert property (
    master_abort |=> s_q.sticky[17])
    else $error("abort did not set flag");
  a_parity_stops_dma: assert property (
    parity_stop_s |=> (s_q.sticky[16] && !dma_program_enable))
    else $error("fetch parity error did not stop dma");
  a_parity_any: assert property (
    any_parity_err |=> s_q.sticky[15])
    else $error("parity flag not set");
  a_set_beats_clear: assert property (
    instr_irq |=> s_q.sticky[11])
    else $error("event lost against clear");
  a_sticky_hold: assert property (
    (s_q.sticky[8] && !do_write) |=> s_q.sticky[8])
    else $error("sticky bit dropped without write");
  a_ack_clear: assert property (
    (serial_bus_done && !serial_ok) |=> !s_q.ack)
    else $error("ack not cleared on unacked done");
  a_ack_set: assert property (
    serial_ok |=> s_q.ack)
    else $error("ack not set on good completion");
  a_field_follow: assert property (
    1'b1 |=> s_q.field == $past(field_even))
    else $error("field bit does not follow");
  a_pstat_set: assert property (
    (pstat_set[0] && !pstat_clr[0]) |=> s_q.pstat[0])
    else $error("program status bit not set");
  a_pstat_clear: assert property (
    pstat_clr[0] |=> !s_q.pstat[0])
    else $error("program status bit not cleared");
  a_opcode_sets: assert property (
    bad_opcode |=> s_q.sticky[18])
    else $error("opcode error not flagged");
  a_sync_count_sets: assert property (
    (eol_overflow || sync_mismatch) |=> s_q.sticky[19])
    else $error("sync count error not flagged");
  a_resync_sets: assert property (
    stream_resync |=> s_q.sticky[14])
    else $error("resync flag not set");
  a_latency_sets: assert property (
    target_latency_overrun |=> s_q.sticky[13])
    else $error("latency overrun flag not set");
  a_dropped_sets: assert property (
    dropped_data_overrun |=> s_q.sticky[12])
    else $error("dropped data flag not set");
  a_pin_level: assert property (
    (!s_q.ctl[CTL_EDGE_BIT] && pin_in) |=> s_q.sticky[9])
    else $error("pin level did not set flag");
  a_pin_edge: assert property (
    pin_rise_s |=> s_q.sticky[9])
    else $error("pin edge did not set flag");
  a_done_sets: assert property (
    serial_bus_done |=> s_q.sticky[8])
    else $error("serial done flag not set");
  a_presence_sets: assert property (
    video_presence_change |=> s_q.sticky[5])
    else $error("presence flag not set");
  a_lock_sets: assert property (
    horizontal_lock_change |=> s_q.sticky[4])
    else $error("lock flag not set");
  a_adc_overflow: assert property (
    converter_overflow |=> s_q.sticky[3])
    else $error("converter overflow flag not set");
  a_line_sets: assert property (
    new_line |=> s_q.sticky[2])
    else $error("line start flag not set");
  a_field_chg_sets: assert property (
    field_change |=> s_q.sticky[1])
    else $error("field change flag not set");
  a_format_sets: assert property (
    format_change |=> s_q.sticky[0])
    else $error("format change flag not set");

endmodule

// >>> pkg/irq_status_pkg.sv
// Purpose: constants for the capture interrupt status block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   offsets are byte addresses
package irq_status_pkg;
  localparam logic [11:0] ADDR_STATUS  = 12'h100;
  localparam logic [11:0] ADDR_MASK    = 12'h104;
  localparam logic [11:0] ADDR_CONTROL = 12'h10C;
  localparam int          MASK_W       = 24;
  localparam logic [23:0] STICKY_BITS  = 24'h0FFB3F;
  localparam int          PSTAT_LSB    = 28;
  localparam int          RUN_BIT      = 27;
  localparam int          ACK_BIT      = 25;
  localparam int          FIELD_BIT    = 24;
  localparam int          CTL_EDGE_BIT = 15;
  localparam int          CTL_INV_BIT  = 14;
  localparam int          CTL_DMA_BIT  = 1;
  localparam int          CTL_FIFO_BIT = 0;
  localparam logic [31:0] CTL_WMASK    = 32'h0000C003;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [23:0] MASK_RESET   = 24'h000000;
  localparam logic [31:0] CTL_RESET    = 32'h00000000;
endpackage

// >>> tb/tb.sv
// Purpose: self-checking bench for capture_interrupt_status
// Assumes: one write and one read in flight; answers sampled at negedge
// Notes:   events packed in ev so one loop reaches every sticky flag except the pin flag (bit 9)
`timescale 1ns/1ps
module tb;
  import irq_status_pkg::*;
  logic        aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, pstat_set, pstat_clr;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        serial_ok, field_even, parity_resp_en;
  logic        general_interrupt_pin, horizontal_reset_input;
  logic        dma_program_enable, fifo_enable, irq;
  logic [18:0] ev;
  int          failures, total_checks;
  int          pos [19] = '{19, 19, 18, 18, 17, 17, 16, 15, 14, 13, 12,
                            11, 8, 5, 4, 3, 2, 1, 0};

  capture_interrupt_status u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pstat_set(pstat_set),
    .pstat_clr(pstat_clr), .serial_ok(serial_ok), .field_even(field_even),
    .parity_resp_en(parity_resp_en),
    .general_interrupt_pin(general_interrupt_pin),
    .horizontal_reset_input(horizontal_reset_input),
    .dma_program_enable(dma_program_enable), .fifo_enable(fifo_enable),
    .irq(irq),
    .eol_overflow(ev[0]), .sync_mismatch(ev[1]), .bad_opcode(ev[2]),
    .bad_sync_status(ev[3]), .master_abort(ev[4]), .target_abort(ev[5]),
    .fetch_parity_err(ev[6]), .any_parity_err(ev[7]),
    .stream_resync(ev[8]), .target_latency_overrun(ev[9]),
    .dropped_data_overrun(ev[10]), .instr_irq(ev[11]),
    .serial_bus_done(ev[12]), .video_presence_change(ev[13]),
    .horizontal_lock_change(ev[14]), .converter_overflow(ev[15]),
    .new_line(ev[16]), .field_change(ev[17]), .format_change(ev[18])
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // valid and payload held until the negedge sample shows ready high
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit ta, tw, tbv;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tbv = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tbv) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    chk(32'h0, 32'h1, "write hang");
  endtask

  task automatic rdreg(input logic [11:0] a);
    bit ta, tv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tv = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tv) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    chk(32'h0, 32'h1, "read hang");
  endtask

  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
    repeat (3) @(negedge aclk);
  endtask

  task automatic t_reset_values();
    rdreg(ADDR_STATUS);
    chk(rd, 32'h0, "status reset");
    rdreg(ADDR_MASK);
    chk(rd, 32'h0, "mask reset");
    rdreg(ADDR_CONTROL);
    chk(rd, CTL_RESET, "control reset");
    chk(32'(irq), 32'h0, "irq reset");
  endtask

  task automatic t_event_flags();
    for (int i = 0; i < 19; i++) begin
      pulse(i);
      rdreg(ADDR_STATUS);
      chk(rd & 32'h00FFFFFF, 32'h1 << pos[i], "event flag");
      chk(32'(irq), 32'h0, "masked irq");
      wr(ADDR_STATUS, rd);
      rdreg(ADDR_STATUS);
      chk(rd & 32'h00FFFFFF, 32'h0, "write back clear");
    end
  endtask

  task automatic t_mask_irq();
    pulse(15);
    pulse(18);
    wr(ADDR_STATUS, 32'h8);
    rdreg(ADDR_STATUS);
    chk(rd & 32'h00FFFFFF, 32'h1, "zero keeps bit");
    wr(ADDR_MASK, 32'h1);
    repeat (3) @(negedge aclk);
    chk(32'(irq), 32'h1, "unmask pending");
    repeat (20) @(negedge aclk);
    chk(32'(irq), 32'h1, "irq level held");
    wr(ADDR_MASK, 32'h2);
    repeat (3) @(negedge aclk);
    chk(32'(irq), 32'h0, "other bit masked");
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    repeat (3) @(negedge aclk);
    chk(32'(irq), 32'h0, "irq after clear");
    wr(ADDR_MASK, 32'h0);
  endtask

  // the event lands on the very edge at which the write-back clear executes
  task automatic t_set_clear();
    fork
      wr(ADDR_STATUS, 32'h800);
      begin
        repeat (2) @(posedge aclk);
        ev[11] <= 1'b1;
        @(posedge aclk);
        ev[11] <= 1'b0;
      end
    join
    rdreg(ADDR_STATUS);
    chk(rd & 32'h800, 32'h800, "set beats clear");
    wr(ADDR_STATUS, 32'h800);
    rdreg(ADDR_STATUS);
    chk(rd & 32'h800, 32'h0, "later clear");
  endtask

  // status-only bits must not raise irq even with every mask bit open
  task automatic t_status_bits();
    wr(ADDR_MASK, 32'hFFFFFFFF);
    rdreg(ADDR_MASK);
    chk(rd, 32'h00FFFFFF, "mask width");
    @(posedge aclk);
    pstat_set <= 4'hA;
    serial_ok <= 1'b1;
    field_even <= 1'b1;
    @(posedge aclk);
    pstat_set <= 4'h0;
    serial_ok <= 1'b0;
    pstat_clr <= 4'h8;
    @(posedge aclk);
    pstat_clr <= 4'h0;
    wr(ADDR_CONTROL, 32'h2);
    rdreg(ADDR_STATUS);
    chk(rd & 32'hFB000000, 32'h2B000000, "status bits");
    chk(32'(irq), 32'h0, "status no irq");
    @(posedge aclk);
    field_even <= 1'b0;
    pulse(12);
    rdreg(ADDR_STATUS);
    chk(rd & 32'h03000100, 32'h00000100, "unacked done");
    pulse(6);
    chk(32'(dma_program_enable), 32'h0, "dma stop");
    rdreg(ADDR_STATUS);
    chk(rd & 32'h08010000, 32'h00010000, "fetch parity");
    @(posedge aclk);
    parity_resp_en <= 1'b0;
    wr(ADDR_CONTROL, 32'h2);
    pulse(6);
    chk(32'(dma_program_enable), 32'h1, "dma kept");
    pulse(7);
    rdreg(ADDR_STATUS);
    chk(rd & 32'h00008000, 32'h00008000, "bus parity");
    @(posedge aclk);
    parity_resp_en <= 1'b1;
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_STATUS, 32'h00FFFFFF);
    wr(ADDR_MASK, 32'h0);
  endtask

  // pin passes a synchroniser, so each change gets ten cycles
  task automatic t_gp_pin(input logic [31:0] ctl, input logic lvl,
                          input logic [31:0] exp);
    wr(ADDR_CONTROL, ctl);
    wr(ADDR_STATUS, 32'h200);
    @(posedge aclk);
    general_interrupt_pin <= lvl;
    repeat (10) @(posedge aclk);
    rdreg(ADDR_STATUS);
    chk(rd & 32'h200, exp, "pin event");
  endtask

  task automatic t_line_reset();
    @(posedge aclk);
    horizontal_reset_input <= 1'b1;
    repeat (3) @(negedge aclk);
    rdreg(ADDR_STATUS);
    chk(rd & 32'h4, 32'h4, "horizontal_reset_input edge");
    wr(ADDR_STATUS, 32'h4);
    rdreg(ADDR_STATUS);
    chk(rd & 32'h4, 32'h0, "horizontal_reset_input level");
    @(posedge aclk);
    horizontal_reset_input <= 1'b0;
  endtask

  task automatic t_unmapped();
    rdreg(12'h108);
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    wr(12'h108, 32'hFFFFFFFF);
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped write");
    wr(ADDR_CONTROL, 32'hFFFFFFFF);
    rdreg(ADDR_CONTROL);
    chk(rd, CTL_WMASK, "control bits");
    chk(32'(fifo_enable), 32'h1, "fifo enable");
    wr(ADDR_CONTROL, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    report_and_stop();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, serial_ok, field_even} = 4'h0;
    {general_interrupt_pin, horizontal_reset_input} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, ev, pstat_set, pstat_clr} = 51'h0;
    {s_axi_wdata, s_axi_wstrb} = {32'h0, 4'hF};
    parity_resp_en = 1'b1;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_event_flags();
    t_mask_irq();
    t_set_clear();
    t_status_bits();
    t_gp_pin(32'h0, 1'b1, 32'h200);
    t_gp_pin(32'h4000, 1'b1, 32'h0);
    t_gp_pin(32'h4000, 1'b0, 32'h200);
    t_gp_pin(32'hC000, 1'b0, 32'h0);
    t_gp_pin(32'hC000, 1'b1, 32'h0);
    t_gp_pin(32'hC000, 1'b0, 32'h200);
    t_gp_pin(32'h8000, 1'b1, 32'h200);
    wr(ADDR_CONTROL, 32'h0);
    t_line_reset();
    t_unmapped();
    report_and_stop();
  end
endmodule
